// [msru_consts.svh]
`ifndef MSRU_CONSTS_SVH
`define MSRU_CONSTS_SVH
// register byte offsets
`define MSRU_A_CTRL 8'h00
`define MSRU_A_CFG 8'h04
`define MSRU_A_RDATA 8'h08
`define MSRU_A_STAT 8'h0c
// control register bits
`define MSRU_C_STATRD 0
`define MSRU_C_SRST 1
// config register bits
`define MSRU_F_BYPASS 0
`define MSRU_F_SHAFT 1
`define MSRU_F_SETTLE 2
`define MSRU_F_FINISH 3
`define MSRU_F_MRK_LO 4
`define MSRU_F_MRK_HI 5
// reply data word: byte plus valid flag
`define MSRU_RD_VALID 8
// response lengths and codes
`define MSRU_LEN_STAT 8'h04
`define MSRU_COD_STAT 8'h4d
`define MSRU_LEN_RST 8'h01
`define MSRU_COD_RST 8'hff
`define MSRU_LEN_STOP 8'h06
`define MSRU_COD_STOP 8'he0
`define MSRU_LEN_HOLD 8'h01
`define MSRU_COD_HOLD 8'he2
`define MSRU_LEN_OK 8'h01
`define MSRU_COD_OK 8'he8
`define MSRU_LEN_FAIL 8'h02
`define MSRU_COD_FAIL 8'hf7
`define MSRU_FAIL_FULL 8'h00
`define MSRU_FAIL_TRIG 8'h01
// headers
`define MSRU_HDR_NOTE 8'h23
`define MSRU_HDR_LO 3'b011
`define MSRU_HDR_HI 3'b000
// byte positions inside a frame
`define MSRU_I_HDR 3'h0
`define MSRU_I_LEN 3'h1
`define MSRU_I_COD 3'h2
`define MSRU_I_P0 3'h3
`define MSRU_I_P1 3'h4
`define MSRU_I_P2 3'h5
`define MSRU_I_P3 3'h6
`define MSRU_I_P4 3'h7
`define MSRU_NPEND 6
`define MSRU_CNT_MAX 4'hf
`endif

// [msru_pkg.sv]
`default_nettype none
package msru_pkg;
  typedef enum logic [2:0] {
    FR_RST = 3'b000,
    FR_STAT = 3'b001,
    FR_STOP = 3'b010,
    FR_HOLD = 3'b011,
    FR_OK = 3'b100,
    FR_FAIL = 3'b101
  } msru_frame_t;
  typedef enum logic {
    SQ_IDLE = 1'b0,
    SQ_SEND = 1'b1
  } msru_seq_t;
  typedef struct packed {
    logic bypass;
    logic shaft;
    logic settle;
    logic finish;
    logic [1:0] marker;
  } msru_cfg_t;
  typedef struct packed {
    msru_cfg_t cfg;
    logic [3:0] ov_cnt;
    logic [5:0] pend;
    logic [7:0] stop_cause;
    logic [31:0] stop_pos;
    logic [7:0] fail_cause;
    logic [23:0] snap;
    msru_seq_t seq;
    msru_frame_t ft;
    logic [2:0] idx;
    logic ack;
    logic [31:0] dat;
    logic hold;
    logic srst;
  } msru_state_t;
endpackage : msru_pkg
`default_nettype wire

// [msru_top.sv]
`timescale 1ns/100ps
`default_nettype none
`include "msru_consts.svh"
// Notes on behaviour
// - status read answers length 04, code 4d, then operation, condition, buffer.
// - operation bit 7 is 0 when run input watched, 1 when ignored.
// - operation bit 6 shows interlock, clears on release or next action.
// - operation bit 4 is 1 while encoder watching is on.
// - operation bit 3 is 1 while in-position watching is on.
// - operation bit 2 is 1 while finish-signal control is used.
// - operation bit 1 flags encoder out of range; undefined when off.
// - operation bit 0 flags outside in-position range; undefined when off.
// - condition bits 5..0: run wait, alarm, constant, ramping, normal, initial.
// - buffer bits 7..4 flag event and override slots occupied.
// - override count rises on registration, falls on execution.
// - software reset restores reset state, then answers length 01 code ff.
// - pulse stop answers length 06 code e0, cause, position MSB first; stops while one is queued share one reply with the latest values.
// - stop cause byte carries a 1 for the cause that applied.
// - start of a run-held operation answers length 01 code e2.
// - successful command buffer store answers length 01 code e8.
// - failed store answers length 02 code f7 and a cause byte.
// - failure cause 00 means buffer full, 01 means triggers in use.
// - watched run input low holds pulse output; unwatched, output proceeds.
module msru_top
  import msru_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic interlock_i,
  input wire logic fb_out_i,
  input wire logic settle_exc_i,
  input wire logic [5:0] cond_i,
  input wire logic [3:0] slot_used_i,
  input wire logic ov_reg_i,
  input wire logic ov_exec_i,
  input wire logic stop_i,
  input wire logic [7:0] stop_cause_i,
  input wire logic [31:0] stop_pos_i,
  input wire logic hold_start_i,
  input wire logic reg_ok_i,
  input wire logic reg_fail_i,
  input wire logic fail_full_i,
  input wire logic pulsing_i,
  input wire logic run_in_i,
  output logic pulse_hold_o,
  output logic soft_reset_o
);

  msru_state_t s_r;
  msru_state_t s_nxt;

  // frame length byte per kind
  function automatic logic [7:0] frame_len(input msru_frame_t ft);
    unique case (ft)
      FR_RST: frame_len = `MSRU_LEN_RST;
      FR_STAT: frame_len = `MSRU_LEN_STAT;
      FR_STOP: frame_len = `MSRU_LEN_STOP;
      FR_HOLD: frame_len = `MSRU_LEN_HOLD;
      FR_OK: frame_len = `MSRU_LEN_OK;
      default: frame_len = `MSRU_LEN_FAIL;
    endcase
  endfunction : frame_len

  // response code per kind
  function automatic logic [7:0] frame_code(input msru_frame_t ft);
    unique case (ft)
      FR_RST: frame_code = `MSRU_COD_RST;
      FR_STAT: frame_code = `MSRU_COD_STAT;
      FR_STOP: frame_code = `MSRU_COD_STOP;
      FR_HOLD: frame_code = `MSRU_COD_HOLD;
      FR_OK: frame_code = `MSRU_COD_OK;
      default: frame_code = `MSRU_COD_FAIL;
    endcase
  endfunction : frame_code

  // byte idx of the frame being sent
  function automatic logic [7:0] frame_byte(input msru_state_t s);
    logic unsol;
    unsol = (s.ft == FR_STOP) || (s.ft == FR_HOLD);
    frame_byte = 8'h00;
    unique case (s.idx)
      `MSRU_I_HDR: begin
        // notifications carry their own fixed header
        frame_byte = unsol ? `MSRU_HDR_NOTE :
          {`MSRU_HDR_HI, s.cfg.marker, `MSRU_HDR_LO};
      end
      `MSRU_I_LEN: frame_byte = frame_len(s.ft);
      `MSRU_I_COD: frame_byte = frame_code(s.ft);
      `MSRU_I_P0: begin
        if (s.ft == FR_STAT) begin
          frame_byte = s.snap[23:16];
        end else if (s.ft == FR_STOP) begin
          frame_byte = s.stop_cause;
        end else begin
          frame_byte = s.fail_cause;
        end
      end
      `MSRU_I_P1: begin
        frame_byte = (s.ft == FR_STAT) ? s.snap[15:8] : s.stop_pos[31:24];
      end
      `MSRU_I_P2: begin
        frame_byte = (s.ft == FR_STAT) ? s.snap[7:0] : s.stop_pos[23:16];
      end
      `MSRU_I_P3: frame_byte = s.stop_pos[15:8];
      `MSRU_I_P4: frame_byte = s.stop_pos[7:0];
    endcase
  endfunction : frame_byte

  // live status bytes: operation, condition, buffer
  logic [23:0] live_stat;
  always_comb begin
    live_stat[23] = s_r.cfg.bypass;
    live_stat[22] = interlock_i;
    live_stat[21] = 1'b0;
    live_stat[20] = s_r.cfg.shaft;
    live_stat[19] = s_r.cfg.settle;
    live_stat[18] = s_r.cfg.finish;
    // undefined range flags forced low while watching is off
    live_stat[17] = fb_out_i & s_r.cfg.shaft;
    live_stat[16] = settle_exc_i & s_r.cfg.settle;
    live_stat[15:8] = {2'b00, cond_i};
    live_stat[7:0] = {slot_used_i, s_r.ov_cnt};
  end

  logic req;
  logic [7:0] last_idx;
  assign req = wb_cyc_i & wb_stb_i & ~s_r.ack;
  assign last_idx = frame_len(s_r.ft) + 8'h01;

  // next state of the whole block
  always_comb begin
    logic [5:0] set;
    logic [2:0] pick;
    logic have;
    logic rd_pop;
    logic do_srst;
    s_nxt = s_r;
    set = 6'h00;
    pick = 3'h0;
    have = 1'b0;
    rd_pop = 1'b0;
    do_srst = 1'b0;
    s_nxt.ack = 1'b0;
    s_nxt.srst = 1'b0;

    // wishbone slave: one-cycle ack per request
    if (req) begin
      s_nxt.ack = 1'b1;
      s_nxt.dat = 32'h0;
      if (wb_we_i) begin
        if (wb_adr_i == `MSRU_A_CTRL && wb_sel_i[0]) begin
          set[FR_STAT] = wb_dat_i[`MSRU_C_STATRD];
          do_srst = wb_dat_i[`MSRU_C_SRST];
        end
        if (wb_adr_i == `MSRU_A_CFG && wb_sel_i[0]) begin
          s_nxt.cfg.bypass = wb_dat_i[`MSRU_F_BYPASS];
          s_nxt.cfg.shaft = wb_dat_i[`MSRU_F_SHAFT];
          s_nxt.cfg.settle = wb_dat_i[`MSRU_F_SETTLE];
          s_nxt.cfg.finish = wb_dat_i[`MSRU_F_FINISH];
          s_nxt.cfg.marker =
            wb_dat_i[`MSRU_F_MRK_HI:`MSRU_F_MRK_LO];
        end
      end else begin
        unique case (wb_adr_i)
          `MSRU_A_CFG: begin
            s_nxt.dat[`MSRU_F_MRK_HI:0] = s_r.cfg;
          end
          `MSRU_A_RDATA: begin
            // each read hands out the next reply byte once
            if (s_r.seq == SQ_SEND) begin
              s_nxt.dat[7:0] = frame_byte(s_r);
              s_nxt.dat[`MSRU_RD_VALID] = 1'b1;
              rd_pop = 1'b1;
            end
          end
          `MSRU_A_STAT: s_nxt.dat[23:0] = live_stat;
          default: s_nxt.dat = 32'h0;
        endcase
      end
    end

    if (ov_reg_i && !ov_exec_i && s_r.ov_cnt != `MSRU_CNT_MAX) begin
      s_nxt.ov_cnt = s_r.ov_cnt + 4'h1;
    end else if (ov_exec_i && !ov_reg_i && s_r.ov_cnt != 4'h0) begin
      s_nxt.ov_cnt = s_r.ov_cnt - 4'h1;
    end

    // capture cause and position at the stop
    if (stop_i) begin
      s_nxt.stop_cause = stop_cause_i;
      s_nxt.stop_pos = stop_pos_i;
    end
    if (reg_fail_i) begin
      s_nxt.fail_cause = fail_full_i ? `MSRU_FAIL_FULL : `MSRU_FAIL_TRIG;
    end
    set[FR_STOP] = stop_i;
    set[FR_HOLD] = hold_start_i;
    set[FR_OK] = reg_ok_i;
    set[FR_FAIL] = reg_fail_i;
    // done reply one cycle after the reset pulse
    set[FR_RST] = s_r.srst;

    // sequencer: advance on pop, pick lowest pending kind when idle
    if (rd_pop) begin
      if ({5'h00, s_r.idx} == last_idx) begin
        s_nxt.seq = SQ_IDLE;
        s_nxt.idx = 3'h0;
      end else begin
        s_nxt.idx = s_r.idx + 3'h1;
      end
    end
    if (s_r.seq == SQ_IDLE) begin
      for (int i = `MSRU_NPEND - 1; i >= 0; i--) begin
        if (s_r.pend[i]) begin
          pick = 3'(i);
          have = 1'b1;
        end
      end
      if (have) begin
        s_nxt.seq = SQ_SEND;
        s_nxt.ft = msru_frame_t'(pick);
        s_nxt.idx = 3'h0;
        s_nxt.pend[pick] = 1'b0;
        // status bytes frozen for the whole reply
        if (msru_frame_t'(pick) == FR_STAT) begin
          s_nxt.snap = live_stat;
        end
      end
    end
    // new events win over the clear of a taken kind
    s_nxt.pend = s_nxt.pend | set;

    // hold pulses while watched run input is low
    s_nxt.hold = pulsing_i & ~s_nxt.cfg.bypass & ~run_in_i;

    // software reset, same as power-up; bus answer still given
    if (do_srst) begin
      s_nxt = '0;
      s_nxt.ack = 1'b1;
      s_nxt.srst = 1'b1;
    end
  end

  // single register of the whole state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign wb_dat_o = s_r.dat;
  assign wb_ack_o = s_r.ack;
  assign pulse_hold_o = s_r.hold;
  assign soft_reset_o = s_r.srst;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // helpers for checks
  logic rd_data;
  assign rd_data = req && !wb_we_i && wb_adr_i == `MSRU_A_RDATA;

  sequence sq_frame_start(msru_frame_t f);
    s_r.seq == SQ_IDLE ##1 s_r.seq == SQ_SEND && s_r.ft == f;
  endsequence

  sequence sq_srst_pulse;
    s_r.srst ##1 !s_r.srst;
  endsequence

  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held more than one cycle");

  a_stat_length: assert property (
    s_r.seq == SQ_SEND && s_r.ft == FR_STAT && s_r.idx == `MSRU_I_LEN
    && rd_data |=> wb_dat_o[7:0] == `MSRU_LEN_STAT)
    else $error("status reply length wrong");

  a_bypass_bit: assert property (
    req && wb_we_i && wb_adr_i == `MSRU_A_CFG && wb_sel_i[0]
    |=> live_stat[23] == $past(wb_dat_i[`MSRU_F_BYPASS]))
    else $error("bypass bit wrong");

  // range flag masked while watching off
  a_range_mask: assert property (
    req && !wb_we_i && wb_adr_i == `MSRU_A_STAT && !s_r.cfg.shaft
    |=> !wb_dat_o[17])
    else $error("range flag leaks when watching off");

  a_count_up: assert property (
    ov_reg_i && !ov_exec_i && s_r.ov_cnt != `MSRU_CNT_MAX && !s_nxt.srst
    |=> s_r.ov_cnt == $past(s_r.ov_cnt) + 4'h1)
    else $error("override count did not rise");

  // reset done reply follows reset pulse
  a_srst_reply: assert property (
    sq_srst_pulse |-> s_r.pend[FR_RST] || s_r.ft == FR_RST)
    else $error("reset reply not raised");

  a_stop_queued: assert property (
    stop_i && !s_nxt.srst |=> s_r.pend[FR_STOP])
    else $error("stop reply lost");

  a_stop_cause: assert property (
    stop_i && !s_nxt.srst |=> s_r.stop_cause == $past(stop_cause_i))
    else $error("stop cause not captured");

  // snapshot taken at status frame start
  a_stat_snap: assert property (
    sq_frame_start(FR_STAT) |-> s_r.snap == $past(live_stat))
    else $error("status snapshot wrong");

  a_fail_cause: assert property (
    reg_fail_i && !s_nxt.srst |=> s_r.fail_cause ==
      ($past(fail_full_i) ? `MSRU_FAIL_FULL : `MSRU_FAIL_TRIG))
    else $error("failure cause wrong");

  a_hold_out: assert property (
    pulsing_i && !run_in_i && !s_r.cfg.bypass && !s_nxt.srst
    && !(req && wb_we_i) |=> pulse_hold_o)
    else $error("pulse not held");

  a_count_down: assert property (
    ov_exec_i && !ov_reg_i && s_r.ov_cnt != 4'h0 && !s_nxt.srst
    |=> s_r.ov_cnt == $past(s_r.ov_cnt) - 4'h1)
    else $error("override count did not fall");

  // soft reset leaves config and count cleared
  a_srst_clear: assert property (
    soft_reset_o |-> s_r.cfg == '0 && s_r.ov_cnt == 4'h0)
    else $error("soft reset left state behind");

  a_stop_pos: assert property (
    stop_i && !s_nxt.srst |=> s_r.stop_pos == $past(stop_pos_i))
    else $error("stop position not captured");

  a_hold_queued: assert property (
    hold_start_i && !s_nxt.srst |=> s_r.pend[FR_HOLD])
    else $error("hold notice lost");

  a_ok_queued: assert property (
    reg_ok_i && !s_nxt.srst |=> s_r.pend[FR_OK])
    else $error("success reply lost");

  a_fail_queued: assert property (
    reg_fail_i && !s_nxt.srst |=> s_r.pend[FR_FAIL])
    else $error("failure reply lost");

endmodule : msru_top
`default_nettype wire

// [msru_host.sv]
`timescale 1ns/100ps
`default_nettype none
// host processor seen from the block: a classic bus master
module msru_host (
  input wire logic clk_i,
  input wire logic ack_i,
  input wire logic [31:0] dat_i,
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [3:0] sel_o,
  output logic [7:0] adr_o,
  output logic [31:0] dat_o
);
  // idle bus from time zero
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o = 1'b0;
    sel_o = 4'h0;
    adr_o = 8'h00;
    dat_o = 32'h0;
  end
  // one cycle; ack is read before the edge's own updates land
  task xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd,
    output logic [31:0] rd);
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= we;
    sel_o <= 4'hf;
    adr_o <= adr;
    dat_o <= wd;
    do @(posedge clk_i); while (ack_i !== 1'b1);
    rd = dat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
  endtask : xfer
  // bytes in order
  // polls are bounded so an absent reply shows as a short frame
  task get_frame(output logic [63:0] f, output int n);
    logic [31:0] d;
    int k;
    int tries;
    f = 64'h0;
    n = 8;
    k = 0;
    tries = 0;
    while (k < n && tries < 40) begin
      xfer(1'b0, 8'h08, 32'h0, d);
      tries++;
      if (d[8] === 1'b1) begin
        f[63-8*k -: 8] = d[7:0];
        if (k == 1) n = (d[7:0] > 8'h06) ? 8 : int'(d[7:0]) + 2;
        k++;
      end
    end
    n = k;
  endtask : get_frame
endmodule : msru_host
`default_nettype wire

// [motion_status_response_unit_bench.sv]
`timescale 1ns/100ps
`default_nettype none
module motion_status_response_unit_bench;
  logic clk = 1'b0, rst = 1'b1, cyc, stb, we, ack, ilk = 0, fb = 0, sx = 0;
  logic [7:0] adr, cause = 8'h00;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, pos = 32'h0, d;
  logic [5:0] cond = 6'h00, ev = 6'h00, cfg;
  logic [3:0] slots = 4'h0;
  logic ffull = 0, pulsing = 0, run_in = 0, hold_o, srst_o;
  logic [63:0] f;
  int errors = 0, n_tests = 0, n;
  logic [7:0] op;
  // 100 MHz
  always #5 clk = ~clk;
  msru_top i_msru_top (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .interlock_i(ilk),
    .fb_out_i(fb), .settle_exc_i(sx), .cond_i(cond), .slot_used_i(slots),
    .ov_reg_i(ev[4]), .ov_exec_i(ev[5]), .stop_i(ev[0]),
    .stop_cause_i(cause), .stop_pos_i(pos), .hold_start_i(ev[1]),
    .reg_ok_i(ev[2]), .reg_fail_i(ev[3]), .fail_full_i(ffull),
    .pulsing_i(pulsing), .run_in_i(run_in), .pulse_hold_o(hold_o),
    .soft_reset_o(srst_o));
  msru_host i_msru_host (.clk_i(clk), .ack_i(ack), .dat_i(rdat),
    .cyc_o(cyc), .stb_o(stb), .we_o(we), .sel_o(sel), .adr_o(adr),
    .dat_o(wdat));
  // expected reply header for a marker value
  function automatic logic [7:0] hdr(input logic [1:0] m);
    return {3'b000, m, 3'b011};
  endfunction : hdr
  // expected operation byte; range flags masked when watching is off
  function automatic logic [7:0] op_byte(input logic [5:0] c);
    return {c[0], ilk, 1'b0, c[1], c[2], c[3], fb & c[1], sx & c[2]};
  endfunction : op_byte
  task chk(input logic [63:0] seen, input logic [63:0] exp, input string nm);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task frame(input logic [63:0] e, input int en, input string nm);
    i_msru_host.get_frame(f, n);
    chk(n, en, nm);
    chk(f, e, nm);
  endtask : frame
  // one-cycle event strobe
  task pulse(input int b);
    @(posedge clk);
    ev[b] <= 1'b1;
    @(posedge clk);
    ev <= 6'h00;
  endtask : pulse
  task test_done;
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : test_done
  // watchdog well beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    test_done;
  end
  initial begin
    void'($urandom(32'hfa9a));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    i_msru_host.xfer(1'b0, 8'h04, 32'h0, d);
    chk(d, 0, "cfg after reset");
    i_msru_host.xfer(1'b0, 8'h30, 32'h0, d);
    chk(d, 0, "unmapped read");
    $display("test reset done");
    // random configs and flags, register view and reply frame
    for (int i = 0; i < 6; i++) begin
      d = $urandom;
      cfg = d[5:0];
      @(posedge clk);
      ilk <= d[6];
      fb <= d[7];
      sx <= d[8];
      cond <= d[14:9];
      slots <= d[18:15];
      i_msru_host.xfer(1'b1, 8'h04, {26'h0, cfg}, d);
      op = op_byte(cfg);
      i_msru_host.xfer(1'b0, 8'h0c, 32'h0, d);
      chk(d, {8'h0, op, 2'b00, cond, slots, 4'h0}, "stat");
      i_msru_host.xfer(1'b1, 8'h00, 32'h1, d);
      frame({hdr(cfg[5:4]), 8'h04, 8'h4d, op, 2'b00, cond, slots, 4'h0,
        16'h0}, 6, "status reply");
    end
    $display("test status done");
    // three registrations, one execution
    for (int i = 0; i < 3; i++) pulse(4);
    pulse(5);
    i_msru_host.xfer(1'b0, 8'h0c, 32'h0, d);
    chk(d[3:0], 4'h2, "override count");
    $display("test override done");
    // every stop cause once, random position
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      cause <= 8'h01 << i;
      pos <= $urandom;
      pulse(0);
      frame({8'h23, 8'h06, 8'he0, cause, pos}, 8, "stop");
    end
    $display("test stop done");
    pulse(1);
    frame({8'h23, 8'h01, 8'he2, 40'h0}, 3, "hold reply");
    pulse(2);
    frame({hdr(cfg[5:4]), 8'h01, 8'he8, 40'h0}, 3, "ok reply");
    @(posedge clk);
    ffull <= 1'b1;
    pulse(3);
    frame({hdr(cfg[5:4]), 16'h02f7, 8'h00, 32'h0}, 4, "fail");
    @(posedge clk);
    ffull <= 1'b0;
    pulse(3);
    frame({hdr(cfg[5:4]), 16'h02f7, 8'h01, 32'h0}, 4, "fail");
    $display("test registration done");
    // watched run input low holds output, bypass lets it run
    i_msru_host.xfer(1'b1, 8'h04, 32'h0, d);
    @(posedge clk);
    pulsing <= 1'b1;
    run_in <= 1'b0;
    repeat (3) @(posedge clk);
    chk(hold_o, 1'b1, "held");
    run_in <= 1'b1;
    repeat (3) @(posedge clk);
    chk(hold_o, 1'b0, "run high");
    run_in <= 1'b0;
    i_msru_host.xfer(1'b1, 8'h04, 32'h1, d);
    repeat (3) @(posedge clk);
    chk(hold_o, 1'b0, "bypassed");
    $display("test run hold done");
    // soft reset with a non-zero marker set beforehand
    i_msru_host.xfer(1'b1, 8'h04, 32'h3f, d);
    i_msru_host.xfer(1'b1, 8'h00, 32'h2, d);
    chk(srst_o, 1'b1, "reset pulse");
    frame({hdr(2'b00), 8'h01, 8'hff, 40'h0}, 3, "reset reply");
    i_msru_host.xfer(1'b0, 8'h04, 32'h0, d);
    chk(d, 0, "cfg after soft reset");
    i_msru_host.xfer(1'b0, 8'h0c, 32'h0, d);
    chk(d[3:0], 4'h0, "count after soft reset");
    $display("test soft reset done");
    test_done;
  end
endmodule : motion_status_response_unit_bench
`default_nettype wire
